//--- verilog/port_e_bus_control_pin_select.sv
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module port_e_bus_control_pin_select
  import pin_select_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        expandedModePin,
  input  wire logic        clockUnderTest,
  input  wire logic        extAccess,
  input  wire pin_t        portBitSeven,
  input  wire pin_t        portBitSix,
  output logic             busClockOut,
  output pin_t             portEBitSeven,
  output pin_t             portEBitSix
);

  ctrl_t          ctrl_q;
  logic [7:0]     div_q;
  logic           modeMeta_q;
  logic           modeSync_q;
  logic           testMeta_q;
  logic           testSync_q;
  logic           captured_q;
  logic           expanded_q;
  logic [1:0]     phase_q;
  logic [1:0]     rem_q;
  logic           inStretch_q;
  logic           busDriveWindowN_q;
  logic           slowDividerClock;
  logic [7:0]     awAddr_q;
  logic [31:0]    wData_q;
  logic           wLane0_q;

  // Bus cycle timing: four clk quarters per bus clock period
  logic [1:0]     phaseD;
  logic [1:0]     remD;
  logic           inStretchD;
  logic           boundary;
  logic           eclkD;
  logic           strobeLowD;

  assign boundary   = (phase_q == LAST_PHASE);
  assign phaseD     = phase_q + 2'h1;
  assign remD       = !boundary ? rem_q
                    : (rem_q != 2'h0) ? rem_q - 2'h1
                    : (extAccess ? ctrl_q.stretch : 2'h0);
  assign inStretchD = !boundary ? inStretch_q : (rem_q != 2'h0);
  // Stretch holds the clock high through every extra cycle
  assign eclkD      = (phaseD >= HIGH_PHASE) | inStretchD;
  assign strobeLowD = eclkD && (remD == 2'h0)
                      && (!inStretchD || phaseD == LAST_PHASE);

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q           <= 2'h0;
      rem_q             <= 2'h0;
      inStretch_q       <= 1'b0;
      busClockOut       <= 1'b0;
      busDriveWindowN_q <= 1'b1;
    end else begin
      phase_q           <= phaseD;
      rem_q             <= remD;
      inStretch_q       <= inStretchD;
      busClockOut       <= eclkD;
      busDriveWindowN_q <= ~strobeLowD;
    end
  end

  // Mode strap and clock-under-test inputs cross in through two flops
  always_ff @(posedge clk) begin
    modeMeta_q <= expandedModePin;
    modeSync_q <= modeMeta_q;
    testMeta_q <= clockUnderTest;
    testSync_q <= testMeta_q;
  end

  slow_divider #(.W(DIV_WIDTH)) u_div (
    .clk              (clk),
    .rst              (rst),
    .setting          (div_q),
    .slowDividerClock (slowDividerClock)
  );

  // Pin function selection
  logic strobeOn;
  logic invOn;
  logic trimOn;
  logic testOn;
  pin_t sevenD;
  pin_t sixD;

  assign strobeOn = !ctrl_q.strobeDisable && !ctrl_q.invertedClockSelect;
  assign invOn    = !ctrl_q.strobeDisable && ctrl_q.invertedClockSelect;
  assign trimOn   = ctrl_q.strobeDisable && ctrl_q.trimReferenceEnable;
  assign testOn   = ctrl_q.clockTestEnable && !ctrl_q.queueTrackingOutputEnable;

  assign sevenD = strobeOn ? pin_t'{out: ~strobeLowD, oe: 1'b1}
                : invOn    ? pin_t'{out: ~eclkD, oe: 1'b1}
                : trimOn   ? pin_t'{out: slowDividerClock, oe: 1'b1}
                : portBitSeven;
  assign sixD   = testOn ? pin_t'{out: testSync_q, oe: 1'b1} : portBitSix;

  always_ff @(posedge clk) begin
    if (rst) begin
      portEBitSeven <= '{out: 1'b1, oe: 1'b0};
      portEBitSix   <= '{out: 1'b0, oe: 1'b0};
    end else begin
      portEBitSeven <= sevenD;
      portEBitSix   <= sixD;
    end
  end

  // AXI4-Lite slave, one write and one read at a time
  logic        doWrite;
  logic        wrHit;
  logic [31:0] readMux;
  logic [1:0]  readResp;
  logic [31:0] statusWord;

  // Write and read answer from the same address map
  function automatic logic isMapped(input logic [7:0] addr);
    return (addr == CTRL_OFF) || (addr == DIV_OFF) || (addr == STATUS_OFF);
  endfunction

  assign doWrite    = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wrHit      = isMapped(awAddr_q);
  assign statusWord = {26'h0, portEBitSix.out, portEBitSeven.out, busClockOut,
                       ~busDriveWindowN_q, slowDividerClock, expanded_q};
  assign readMux    = (s_axi_araddr == CTRL_OFF)   ? {25'h0, ctrl_q}
                    : (s_axi_araddr == DIV_OFF)    ? {24'h0, div_q}
                    : (s_axi_araddr == STATUS_OFF) ? statusWord : 32'h0;
  assign readResp   = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awAddr_q      <= 8'h00;
      wData_q       <= 32'h0;
      wLane0_q      <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awAddr_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wData_q      <= s_axi_wdata;
        wLane0_q     <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= readMux;
      s_axi_rresp   <= readResp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Mode strap taken once, the first cycle after reset release
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q     <= CTRL_RESET;
      div_q      <= DIV_RESET;
      captured_q <= 1'b0;
      expanded_q <= 1'b0;
    end else begin
      if (!captured_q) begin
        captured_q           <= 1'b1;
        expanded_q           <= modeSync_q;
        ctrl_q.strobeDisable <= ~modeSync_q;
      end else if (doWrite && wLane0_q && awAddr_q == CTRL_OFF) begin
        ctrl_q <= ctrl_t'(wData_q[CTRL_WIDTH-1:0]);
      end else if (doWrite && wLane0_q && awAddr_q == DIV_OFF) begin
        div_q <= wData_q[DIV_WIDTH-1:0];
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence lastStretchQuarter;
    inStretch_q && rem_q == 2'h0 && phase_q == LAST_PHASE;
  endsequence

  sequence normalHighQuarters;
    !busDriveWindowN_q ##1 !busDriveWindowN_q;
  endsequence

  a_strobe_in_high: assert property (!busDriveWindowN_q |-> busClockOut)
    else $error("strobe low while bus clock low");
  a_stretch_last_quarter: assert property (
    (!busDriveWindowN_q && inStretch_q) |-> lastStretchQuarter)
    else $error("stretched strobe outside last quarter");
  a_stretch_strobe_fires: assert property (
    lastStretchQuarter |-> !busDriveWindowN_q ##1 busDriveWindowN_q)
    else $error("stretched strobe missing");
  a_strobe_on_pin: assert property (
    $past(strobeOn) |-> portEBitSeven.oe && portEBitSeven.out == busDriveWindowN_q)
    else $error("strobe not on shared pin");
  a_reset_strobe_on: assert property (
    (captured_q && !$past(captured_q)) |-> ctrl_q.strobeDisable == !expanded_q)
    else $error("strobe enable wrong after reset");
  a_inverted_clock: assert property (
    $past(invOn) |-> portEBitSeven.out == !busClockOut)
    else $error("inverted clock not opposite bus clock");
  a_trim_reference: assert property (
    $past(trimOn) |-> portEBitSeven.out == $past(slowDividerClock))
    else $error("trim reference not on pin");
  // Pin reset value differs from the port drive, so skip the release edge
  a_port_fallback: assert property (
    (!$past(rst) && $past(ctrl_q.strobeDisable) && !$past(ctrl_q.trimReferenceEnable))
      |-> portEBitSeven == $past(portBitSeven))
    else $error("shared pin not under port control");
  a_test_clock_out: assert property (
    $past(testOn) |-> portEBitSix.oe && portEBitSix.out == $past(testSync_q))
    else $error("test clock not routed");
  a_test_blocked: assert property (
    $past(ctrl_q.queueTrackingOutputEnable) |-> portEBitSix == $past(portBitSix))
    else $error("test clock driven while tracking enabled");
  a_bus_clock_phase: assert property (
    (phase_q == HIGH_PHASE && !inStretch_q) |-> busClockOut ##1 busClockOut)
    else $error("bus clock high phase wrong");

  // Bus clock and strobe shape
  a_bus_clock_low: assert property (
    (phase_q == 2'h0 && !inStretch_q) |-> !busClockOut ##1 !busClockOut)
    else $error("bus clock low phase wrong");
  a_stretch_clock_high: assert property (inStretch_q |-> busClockOut)
    else $error("bus clock low inside stretch");
  a_strobe_idle_high: assert property (
    (phase_q == 2'h0 || phase_q == 2'h1) |-> busDriveWindowN_q)
    else $error("strobe low in first half of bus cycle");
  a_strobe_two_quarters: assert property (
    (phase_q == HIGH_PHASE && !inStretch_q && rem_q == 2'h0) |-> normalHighQuarters)
    else $error("strobe missing in plain bus cycle");

  // Pin routing
  a_inverted_stretch: assert property (
    ($past(invOn) && inStretch_q) |-> !portEBitSeven.out)
    else $error("inverted clock high inside stretch");
  a_trim_overridden: assert property (
    ($past(strobeOn) && $past(ctrl_q.trimReferenceEnable))
      |-> portEBitSeven.oe && portEBitSeven.out == busDriveWindowN_q)
    else $error("trim reference not overridden by strobe");
  a_test_off: assert property (
    (!$past(rst) && !$past(ctrl_q.clockTestEnable)) |-> portEBitSix == $past(portBitSix))
    else $error("bit six pin not under port control");

  // Register bus
  a_read_after_take: assert property (
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered after address taken");
  a_write_answer: assert property (doWrite |=> s_axi_bvalid)
    else $error("write not answered");
  a_ctrl_write: assert property (
    (captured_q && doWrite && wLane0_q && awAddr_q == CTRL_OFF)
      |=> {25'h0, ctrl_q} == ($past(wData_q) & 32'h0000007F))
    else $error("control write lost");
  a_div_write: assert property (
    (captured_q && doWrite && wLane0_q && awAddr_q == DIV_OFF)
      |=> {24'h0, div_q} == ($past(wData_q) & 32'h000000FF))
    else $error("divider write lost");

endmodule

//--- verilog/pin_select_pkg.sv
// Operation
// - Drive window strobe goes low only while bus clock is high.
// - Stretched access: strobe only in final quarter of last stretch cycle.
// - Strobe reaches the shared pin only when strobe disable is clear.
// - Expanded mode after reset enables the strobe function.
// - Inverted bus clock tracks bus clock exactly, stretches included, opposite polarity.
// - Strobe disable plus inverted clock select choose strobe or inverted clock.
// - Trim reference puts the slow divider clock on the shared pin.
// - Slow divider runs at reference rate after reset, always 50% duty.
// - Enabled strobe function overrides an enabled trim reference.
// - Clearing trim reference enable stops driving it on the pin.
// - Clock test enable routes clocks under test to bit six pin.
// - Test clocks only when queue tracking output enable is clear.
// - Bus clock is presented on its own output pin.
package pin_select_pkg;

  localparam logic [7:0] CTRL_OFF    = 8'h00;
  localparam logic [7:0] DIV_OFF     = 8'h04;
  localparam logic [7:0] STATUS_OFF  = 8'h08;

  localparam int         CTRL_WIDTH  = 7;
  localparam int         DIV_WIDTH   = 8;
  localparam logic [7:0] DIV_RESET   = 8'h00;
  localparam logic [1:0] LAST_PHASE  = 2'h3;
  localparam logic [1:0] HIGH_PHASE  = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] stretch;
    logic       queueTrackingOutputEnable;
    logic       clockTestEnable;
    logic       trimReferenceEnable;
    logic       invertedClockSelect;
    logic       strobeDisable;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = ctrl_t'(7'h01);

  typedef struct packed {
    logic out;
    logic oe;
  } pin_t;

endpackage

//--- verilog/slow_divider.sv
`timescale 1ns/10ps
module slow_divider
  import pin_select_pkg::*;
#(
  parameter int W = DIV_WIDTH
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] setting,
  output logic              slowDividerClock
);

  logic [W-1:0] count_q;
  logic         wrap;

  // Toggle every setting+1 cycles: equal halves at any setting
  assign wrap = (count_q >= setting);

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q          <= '0;
      slowDividerClock <= 1'b0;
    end else begin
      count_q          <= wrap ? '0 : count_q + W'(1);
      slowDividerClock <= wrap ? ~slowDividerClock : slowDividerClock;
    end
  end

  a_divider_reset_rate: assert property (@(posedge clk) disable iff (rst)
    ($past(rst) == 1'b0 && $past(setting) == '0 && $past(count_q) == '0)
      |-> slowDividerClock != $past(slowDividerClock))
    else $error("slow divider not at reference rate");

endmodule

//--- test/ext_bus_model.sv
`timescale 1ns/10ps
module ext_bus_model
  import pin_select_pkg::*;
(
  input  wire pin_t strobe,
  output logic      driving
);
  // Read drivers open only inside the low strobe window
  assign driving = strobe.oe & ~strobe.out;
endmodule

//--- test/tb.sv
`timescale 1ns/10ps
module tb
  import pin_select_pkg::*;
;
  logic clk = 0, rst = 1, strap = 1, cut = 0, ext = 1, drv;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, bco;
  logic [1:0] bresp, rresp, r;
  pin_t p7 = '0, p6 = '0, o7, o6;
  int n_mismatch = 0, tests_run = 0;

  always #25 clk = ~clk;
  always #100 cut = ~cut;

  port_e_bus_control_pin_select u_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .expandedModePin(strap),
    .clockUnderTest(cut), .extAccess(ext), .portBitSeven(p7), .portBitSix(p6), .busClockOut(bco),
    .portEBitSeven(o7), .portEBitSix(o6));
  ext_bus_model u_bus (.strobe(o7), .driving(drv));

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    r = bresp;
    bready <= 0;
    @(posedge clk);
  endtask

  task automatic rd(logic [7:0] a);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    r = rresp;
    rready <= 0;
    @(posedge clk);
  endtask

  // Whole bus-clock runs only: count high cycles and strobe-low cycles per run
  task automatic runs(logic [7:0] c, int hi, int lo);
    int h, l;
    logic p;
    wr(CTRL_OFF, {24'h0, c});
    repeat (8) @(posedge clk);
    for (int i = 0; i < 20 && bco; i++) @(posedge clk);
    h = 0; l = 0; p = 0;
    repeat (80) begin
      @(posedge clk);
      if (c[1]) chk("inverted clock", o7, {~bco, 1'b1});
      if (!bco) begin
        if (!c[1]) chk("strobe outside clock high", drv, 0);
        if (p) chk("clock high run", h, hi);
        if (p) chk("strobe cycles per run", l, lo);
        h = 0; l = 0;
      end else begin
        h++;
        if (!c[1]) l += drv;
      end
      p = bco;
    end
  endtask

  task automatic edges(logic [7:0] d, int n, bit six);
    int e;
    logic q;
    wr(DIV_OFF, {24'h0, d});
    repeat (10) @(posedge clk);
    e = 0; q = six ? o6.out : o7.out;
    repeat (48) begin
      @(posedge clk);
      e += ((six ? o6.out : o7.out) != q);
      q = six ? o6.out : o7.out;
    end
    chk("toggle count", e, n);
  endtask

  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #(50 * 30000);
    n_mismatch++;
    wrap_up;
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    repeat (3) @(posedge clk);
    rd(CTRL_OFF);
    chk("ctrl expanded", rdata, 0);
    rd(DIV_OFF);
    chk("div reset", rdata, 0);
    rd(STATUS_OFF);
    chk("status strap", rdata[0], 1);
    rd(8'h0C);
    chk("unmapped read", {rdata[29:0], r}, RESP_SLVERR);
    wr(8'h10, 32'h7F);
    chk("unmapped write", r, RESP_SLVERR);
    for (int s = 0; s < 4; s++) begin
      runs({1'b0, 2'(s), 5'h00}, 2 + 4 * s, (s == 0) ? 2 : 1);
      runs({1'b0, 2'(s), 5'h02}, 2 + 4 * s, 0);
    end
    runs(8'h04, 2, 2);
    ext <= 0;
    runs(8'h60, 2, 2);
    ext <= 1;
    wr(CTRL_OFF, 32'h05);
    edges(8'h00, 48, 0);
    edges(8'h02, 16, 0);
    chk("trim drives pin", o7.oe, 1);
    p7 <= '{out: 1'b1, oe: 1'b1};
    wr(CTRL_OFF, 32'h01);
    repeat (3) @(posedge clk);
    chk("pin7 port control", o7, 2'b11);
    wr(CTRL_OFF, 32'h08);
    edges(8'h00, 24, 1);
    chk("test clock drives", o6.oe, 1);
    p6 <= '{out: 1'b1, oe: 1'b0};
    wr(CTRL_OFF, 32'h18);
    repeat (3) @(posedge clk);
    chk("pin6 blocked", o6, 2'b10);
    strap <= 0;
    rst <= 1;
    repeat (20) @(posedge clk);
    rst <= 0;
    repeat (3) @(posedge clk);
    rd(CTRL_OFF);
    chk("ctrl single chip", rdata, 1);
    wrap_up;
  end
endmodule
